// file: dmh_log.sv
`timescale 1ns/10ps
`default_nettype none
module dmh_log (
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic i_EVT,
	input wire logic [31:0] i_EVT_CODE,
	input wire logic [15:0] i_EVT_TEXT_ID,
	input wire logic [31:0] i_EVT_PARAM,
	input wire logic [63:0] i_SYS_TIME,
	input wire logic i_ACK,
	input wire logic i_EN_WR,
	input wire logic i_EN_DATA,
	input wire logic i_RD_REQ,
	input wire logic [7:0] i_RD_SUBIDX,
	output logic o_RD_VALID,
	output logic [dmh_pkg::ENTRY_W-1:0] o_RD_DATA,
	output logic [7:0] o_NEWEST_SUBIDX,
	output logic o_UNREAD,
	output logic o_EMCY_EN,
	output logic o_EMCY,
	output logic [dmh_pkg::ENTRY_W-1:0] o_EMCY_ENTRY,
	output logic o_TEXT_ID_BAD
);
	dmh_mem_if mbus ();

	dmh_mem u_mem (
		.i_clk(I_CLK),
		.bus(mbus)
	);

	logic [7:0] newest_reg;
	logic [7:0] newest_next;
	logic [7:0] wr_slot_reg;
	logic [7:0] wr_slot_next;
	logic full_reg;
	logic empty_reg;
	logic unread_reg;
	logic emcy_en_reg;
	logic emcy_reg;
	logic bad_reg;
	logic [dmh_pkg::ENTRY_W-1:0] emcy_entry_reg;
	logic [dmh_pkg::SLOTS-1:0] conf_reg;
	logic rd_pend_reg;
	logic [7:0] rd_sub_reg;
	logic rd_conf_reg;
	logic rd_valid_reg;
	logic [dmh_pkg::ENTRY_W-1:0] rd_data_reg;

	// ---------------------------------------------------------------
	// Severity and text identifier decoding.
	// ---------------------------------------------------------------
	wire [3:0] txt_class = i_EVT_TEXT_ID[dmh_pkg::TXT_CLASS_LSB +: 4];
	wire [3:0] txt_cat = i_EVT_TEXT_ID[dmh_pkg::TXT_CAT_LSB +: 4];
	wire class_ok = (txt_class == dmh_pkg::CLASS_SYSINFO) ||
		(txt_class == dmh_pkg::CLASS_INFO) ||
		(txt_class == dmh_pkg::CLASS_RESERVED) ||
		(txt_class == dmh_pkg::CLASS_WARNING) ||
		(txt_class == dmh_pkg::CLASS_ERROR);
	wire cat_ok = (txt_cat <= dmh_pkg::CAT_RESERVED);
	wire [3:0] severity = (txt_class == dmh_pkg::CLASS_ERROR) ?
		dmh_pkg::SEV_ERROR :
		(txt_class == dmh_pkg::CLASS_WARNING) ?
		dmh_pkg::SEV_WARNING : dmh_pkg::SEV_INFO;
	wire [15:0] evt_flags = {12'h000, severity};

	// New entry: code, flags, text, timestamp, parameter.
	wire [dmh_pkg::ENTRY_W-1:0] new_entry = {i_EVT_PARAM, i_SYS_TIME,
		i_EVT_TEXT_ID, evt_flags, i_EVT_CODE};

	// ---------------------------------------------------------------
	// Slot bookkeeping.
	// ---------------------------------------------------------------
	wire [7:0] last_slot = dmh_pkg::ENTRY_COUNT - 8'h01;
	wire [7:0] wr_slot_inc = (wr_slot_reg == last_slot) ? 8'h00 :
		wr_slot_reg + 8'h01;
	wire [7:0] wr_subidx = wr_slot_reg + dmh_pkg::SUB_FIRST_ENTRY;
	wire wrap = i_EVT && (wr_slot_reg == last_slot);
	wire [7:0] newest_slot = newest_reg - dmh_pkg::SUB_FIRST_ENTRY;

	assign wr_slot_next = i_EVT ? wr_slot_inc : wr_slot_reg;
	assign newest_next = i_EVT ? wr_subidx : newest_reg;

	assign mbus.wr_en = i_EVT;
	assign mbus.wr_addr = wr_slot_reg;
	assign mbus.wr_data = new_entry;

	wire is_entry_sub = (i_RD_SUBIDX >= dmh_pkg::SUB_FIRST_ENTRY);
	wire [7:0] rd_slot = i_RD_SUBIDX - dmh_pkg::SUB_FIRST_ENTRY;
	assign mbus.rd_addr = is_entry_sub ? rd_slot : 8'h00;

	// A read of the newest stored entry counts as having seen the news.
	wire newest_read = i_RD_REQ && !empty_reg &&
		(i_RD_SUBIDX == newest_reg);
	wire ack_hit = i_ACK && !empty_reg && !conf_reg[newest_slot];

	// ---------------------------------------------------------------
	// Control state.
	// ---------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			newest_reg <= dmh_pkg::RESET_NEWEST;
			wr_slot_reg <= 8'h00;
			full_reg <= 1'b0;
			empty_reg <= 1'b1;
		end else begin
			newest_reg <= newest_next;
			wr_slot_reg <= wr_slot_next;
			full_reg <= full_reg || wrap;
			empty_reg <= empty_reg && !i_EVT;
		end
	end

	// The store wins over the read that would clear the flag.
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			unread_reg <= 1'b0;
		end else if (i_EVT) begin
			unread_reg <= 1'b1;
		end else if (newest_read) begin
			unread_reg <= 1'b0;
		end
	end

	// A new entry starts unconfirmed; acknowledge marks the newest one.
	genvar g;
	generate
		for (g = 0; g < dmh_pkg::SLOTS; g++) begin : g_conf
			always_ff @(posedge I_CLK or negedge I_NRST) begin
				if (!I_NRST) begin
					conf_reg[g] <= 1'b0;
				end else if (i_EVT && wr_slot_reg == 8'(g)) begin
					conf_reg[g] <= 1'b0;
				end else if (ack_hit && newest_slot == 8'(g)) begin
					conf_reg[g] <= 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			emcy_en_reg <= dmh_pkg::RESET_EMCY_EN;
		end else if (i_EN_WR) begin
			emcy_en_reg <= i_EN_DATA;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			emcy_reg <= 1'b0;
			emcy_entry_reg <= '0;
			bad_reg <= 1'b0;
		end else begin
			emcy_reg <= i_EVT && emcy_en_reg;
			if (i_EVT) begin
				emcy_entry_reg <= new_entry;
				bad_reg <= !(class_ok && cat_ok);
			end
		end
	end

	// ---------------------------------------------------------------
	// Object dictionary read, two edges from request to answer.
	// ---------------------------------------------------------------
	wire [7:0] count = full_reg ? dmh_pkg::ENTRY_COUNT : wr_slot_reg;
	wire stored = is_entry_sub && (full_reg || rd_slot < wr_slot_reg);

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rd_pend_reg <= 1'b0;
			rd_sub_reg <= 8'h00;
			rd_conf_reg <= 1'b0;
		end else begin
			rd_pend_reg <= i_RD_REQ;
			rd_sub_reg <= (is_entry_sub && !stored) ? 8'h00 : i_RD_SUBIDX;
			rd_conf_reg <= is_entry_sub ? conf_reg[rd_slot] : 1'b0;
		end
	end

	logic [dmh_pkg::ENTRY_W-1:0] rd_word;
	always_comb begin
		rd_word = '0;
		case (rd_sub_reg)
			dmh_pkg::SUB_MAX_COUNT: rd_word[7:0] = count;
			dmh_pkg::SUB_NEWEST: rd_word[7:0] = newest_reg;
			dmh_pkg::SUB_FLAGS: rd_word[0] = unread_reg;
			dmh_pkg::SUB_EMCY_EN: rd_word[0] = emcy_en_reg;
			default: begin
				if (rd_sub_reg >= dmh_pkg::SUB_FIRST_ENTRY) begin
					rd_word = mbus.rd_data;
					rd_word[dmh_pkg::FLAGS_LSB + dmh_pkg::FLAG_ACK_BIT] =
						rd_conf_reg;
				end
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rd_valid_reg <= 1'b0;
			rd_data_reg <= '0;
		end else begin
			rd_valid_reg <= rd_pend_reg;
			if (rd_pend_reg) begin
				rd_data_reg <= rd_word;
			end
		end
	end

	assign o_RD_VALID = rd_valid_reg;
	assign o_RD_DATA = rd_data_reg;
	assign o_NEWEST_SUBIDX = newest_reg;
	assign o_UNREAD = unread_reg;
	assign o_EMCY_EN = emcy_en_reg;
	assign o_EMCY = emcy_reg;
	assign o_EMCY_ENTRY = emcy_entry_reg;
	assign o_TEXT_ID_BAD = bad_reg;
endmodule
`default_nettype wire

// file: dmh_log_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dmh_log_sva (
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic i_EVT,
	input wire logic [31:0] i_EVT_CODE,
	input wire logic [15:0] i_EVT_TEXT_ID,
	input wire logic [63:0] i_SYS_TIME,
	input wire logic i_EN_WR,
	input wire logic i_EN_DATA,
	input wire logic i_RD_REQ,
	input wire logic [7:0] i_RD_SUBIDX,
	input wire logic o_RD_VALID,
	input wire logic [7:0] o_NEWEST_SUBIDX,
	input wire logic o_UNREAD,
	input wire logic o_EMCY_EN,
	input wire logic o_EMCY,
	input wire logic [dmh_pkg::ENTRY_W-1:0] o_EMCY_ENTRY
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);
	sequence evt_s;
		i_EVT;
	endsequence
	sequence answer_s;
		##2 o_RD_VALID;
	endsequence
	rd_latency_a: assert property (i_RD_REQ |-> answer_s)
		else $error("read answer not two cycles after request");
	rd_spurious_a: assert property (!i_RD_REQ |-> ##2 !o_RD_VALID)
		else $error("read answer without request");
	emcy_on_a: assert property (i_EVT && o_EMCY_EN |=> o_EMCY)
		else $error("enabled event gave no emergency");
	emcy_cause_a: assert property (o_EMCY |-> $past(i_EVT && o_EMCY_EN))
		else $error("emergency without enabled event");
	en_write_a: assert property (i_EN_WR |=> o_EMCY_EN == $past(i_EN_DATA))
		else $error("enable write not taken");
	entry_fields_a: assert property (evt_s |=>
		o_EMCY_ENTRY[127:0] == {$past(i_SYS_TIME), $past(i_EVT_TEXT_ID),
		o_EMCY_ENTRY[47:32], $past(i_EVT_CODE)})
		else $error("entry time, text or code wrong");
	sev_error_a: assert property (i_EVT && i_EVT_TEXT_ID[15:12] == 4'h8
		|=> o_EMCY_ENTRY[35:32] == 4'h2)
		else $error("error class not flagged as error");
	unread_set_a: assert property (evt_s |=> o_UNREAD)
		else $error("unread flag not set by event");
	unread_clear_a: assert property (i_RD_REQ && !i_EVT &&
		o_NEWEST_SUBIDX != 8'h00 && i_RD_SUBIDX == o_NEWEST_SUBIDX
		|=> !o_UNREAD)
		else $error("reading newest entry left unread flag set");
	newest_wrap_a: assert property (i_EVT && o_NEWEST_SUBIDX == 8'hff
		|=> o_NEWEST_SUBIDX == 8'h06)
		else $error("newest subindex did not wrap to first slot");
	newest_step_a: assert property (i_EVT && o_NEWEST_SUBIDX inside
		{[8'h06:8'hfe]} |=> o_NEWEST_SUBIDX == $past(o_NEWEST_SUBIDX) + 8'h01)
		else $error("newest subindex did not advance by one");
	newest_hold_a: assert property (!i_EVT |=> $stable(o_NEWEST_SUBIDX))
		else $error("newest subindex moved without event");
endmodule
bind dmh_log dmh_log_sva chk (.I_CLK(I_CLK), .I_NRST(I_NRST), .i_EVT(i_EVT),
	.i_EVT_CODE(i_EVT_CODE), .i_EVT_TEXT_ID(i_EVT_TEXT_ID),
	.i_SYS_TIME(i_SYS_TIME), .i_EN_WR(i_EN_WR), .i_EN_DATA(i_EN_DATA),
	.i_RD_REQ(i_RD_REQ), .i_RD_SUBIDX(i_RD_SUBIDX), .o_RD_VALID(o_RD_VALID),
	.o_NEWEST_SUBIDX(o_NEWEST_SUBIDX), .o_UNREAD(o_UNREAD),
	.o_EMCY_EN(o_EMCY_EN), .o_EMCY(o_EMCY), .o_EMCY_ENTRY(o_EMCY_ENTRY));
`default_nettype wire

// file: dmh_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmh_master_model (
	input wire logic i_clk,
	input wire logic i_rd_valid,
	input wire logic [dmh_pkg::ENTRY_W-1:0] i_rd_data,
	output logic o_rd_req,
	output logic [7:0] o_rd_subidx,
	output logic o_ack,
	output logic o_en_wr,
	output logic o_en_data
);
	initial begin
		o_rd_req = 1'b0;
		o_rd_subidx = 8'h00;
		o_ack = 1'b0;
		o_en_wr = 1'b0;
		o_en_data = 1'b0;
	end
	task automatic read(input logic [7:0] sub,
		output logic [dmh_pkg::ENTRY_W-1:0] data);
		int n;
		@(negedge i_clk);
		o_rd_req = 1'b1;
		o_rd_subidx = sub;
		@(negedge i_clk);
		o_rd_req = 1'b0;
		o_rd_subidx = ~sub;
		n = 0;
		while (i_rd_valid !== 1'b1 && n < 4) begin
			@(negedge i_clk);
			n++;
		end
		data = i_rd_data;
	endtask
	task automatic confirm;
		@(negedge i_clk);
		o_ack = 1'b1;
		@(negedge i_clk);
		o_ack = 1'b0;
	endtask
	task automatic set_enable(input logic v);
		@(negedge i_clk);
		o_en_wr = 1'b1;
		o_en_data = v;
		@(negedge i_clk);
		o_en_wr = 1'b0;
		o_en_data = ~v;
	endtask
endmodule
`default_nettype wire

// file: dmh_mem.sv
`timescale 1ns/10ps
`default_nettype none
module dmh_mem (
	input wire logic i_clk,
	dmh_mem_if.mem bus
);
	logic [dmh_pkg::ENTRY_W-1:0] store [0:dmh_pkg::SLOTS-1];
	logic [dmh_pkg::ENTRY_W-1:0] rd_data_reg;

	// Read data always come from a register, one edge after the address.
	always_ff @(posedge i_clk) begin
		if (bus.wr_en) begin
			store[bus.wr_addr] <= bus.wr_data;
		end
		rd_data_reg <= store[bus.rd_addr];
	end

	assign bus.rd_data = rd_data_reg;
endmodule
`default_nettype wire

// file: dmh_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dmh_mem_if;
	logic wr_en;
	logic [dmh_pkg::SLOT_W-1:0] wr_addr;
	logic [dmh_pkg::ENTRY_W-1:0] wr_data;
	logic [dmh_pkg::SLOT_W-1:0] rd_addr;
	logic [dmh_pkg::ENTRY_W-1:0] rd_data;

	modport ctrl (output wr_en, output wr_addr, output wr_data,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data,
		input rd_addr, output rd_data);
endinterface
`default_nettype wire

// file: dmh_pkg.sv
package dmh_pkg;
	// ---------------------------------------------------------------
	// Object layout of the diagnostic history.
	// ---------------------------------------------------------------
	localparam logic [15:0] OBJ_INDEX = 16'h10f3;
	localparam logic [7:0] SUB_MAX_COUNT = 8'h01;
	localparam logic [7:0] SUB_NEWEST = 8'h02;
	localparam logic [7:0] SUB_FLAGS = 8'h04;
	localparam logic [7:0] SUB_EMCY_EN = 8'h05;
	localparam logic [7:0] SUB_FIRST_ENTRY = 8'h06;
	localparam logic [7:0] SUB_LAST_ENTRY = 8'hff;
	localparam logic [7:0] ENTRY_COUNT = 8'hfa;
	localparam int SLOTS = 250;
	localparam int SLOT_W = 8;

	// ---------------------------------------------------------------
	// Entry fields, lowest byte first.
	// ---------------------------------------------------------------
	localparam int CODE_W = 32;
	localparam int FLAGS_W = 16;
	localparam int TEXT_W = 16;
	localparam int TIME_W = 64;
	localparam int PARAM_W = 32;
	localparam int ENTRY_W = CODE_W + FLAGS_W + TEXT_W + TIME_W + PARAM_W;
	localparam int CODE_LSB = 0;
	localparam int FLAGS_LSB = CODE_LSB + CODE_W;
	localparam int TEXT_LSB = FLAGS_LSB + FLAGS_W;
	localparam int TIME_LSB = TEXT_LSB + TEXT_W;
	localparam int PARAM_LSB = TIME_LSB + TIME_W;

	// Flags field: severity in bits 3:0, confirmed mark in bit 4.
	localparam int FLAG_ACK_BIT = 4;
	localparam logic [3:0] SEV_INFO = 4'h0;
	localparam logic [3:0] SEV_WARNING = 4'h1;
	localparam logic [3:0] SEV_ERROR = 4'h2;

	// Text identifier digits: class, category, two number digits.
	localparam int TXT_CLASS_LSB = 12;
	localparam int TXT_CAT_LSB = 8;
	localparam logic [3:0] CLASS_SYSINFO = 4'h0;
	localparam logic [3:0] CLASS_INFO = 4'h1;
	localparam logic [3:0] CLASS_RESERVED = 4'h2;
	localparam logic [3:0] CLASS_WARNING = 4'h4;
	localparam logic [3:0] CLASS_ERROR = 4'h8;
	localparam logic [3:0] CAT_IO_GENERAL = 4'h6;
	localparam logic [3:0] CAT_RESERVED = 4'h7;

	localparam logic [7:0] RESET_NEWEST = 8'h00;
	localparam logic RESET_EMCY_EN = 1'b1;
	localparam int RD_LATENCY = 2;
endpackage

// file: tb_dmh_log.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dmh_log;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic evt = 1'b0;
	logic [31:0] code = 32'h0;
	logic [15:0] text = 16'h0;
	logic [63:0] stime = 64'h0;
	logic ack, en_wr, en_data, rd_req, rd_valid, unread, emcy_en, emcy, bad;
	logic [7:0] sub, newest;
	logic [159:0] rd_data, emcy_entry, got;
	logic [3:0] cls [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int n = 0;
	always #2 clk = ~clk;
	dmh_log dut (.I_CLK(clk), .I_NRST(nrst), .i_EVT(evt), .i_EVT_CODE(code),
		.i_EVT_TEXT_ID(text), .i_EVT_PARAM(~code), .i_SYS_TIME(stime),
		.i_ACK(ack), .i_EN_WR(en_wr), .i_EN_DATA(en_data), .i_RD_REQ(rd_req),
		.i_RD_SUBIDX(sub), .o_RD_VALID(rd_valid), .o_RD_DATA(rd_data),
		.o_NEWEST_SUBIDX(newest), .o_UNREAD(unread), .o_EMCY_EN(emcy_en),
		.o_EMCY(emcy), .o_EMCY_ENTRY(emcy_entry), .o_TEXT_ID_BAD(bad));
	dmh_master_model mst (.i_clk(clk), .i_rd_valid(rd_valid),
		.i_rd_data(rd_data), .o_rd_req(rd_req), .o_rd_subidx(sub),
		.o_ack(ack), .o_en_wr(en_wr), .o_en_data(en_data));
	task automatic complete_run;
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [159:0] g, input logic [159:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	function automatic logic [159:0] entry(input logic [15:0] t,
		input logic [31:0] c);
		logic [3:0] sev;
		sev = (t[15:12] == 4'h8) ? 4'h2 : (t[15:12] == 4'h4) ? 4'h1 : 4'h0;
		return {~c, 32'h5a5a0000, c, t, 12'h000, sev, c};
	endfunction
	task automatic log(input logic [15:0] t, input logic [31:0] c);
		@(negedge clk);
		evt = 1'b1;
		text = t;
		code = c;
		stime = {32'h5a5a0000, c};
		n++;
	endtask
	task automatic idle;
		@(negedge clk);
		evt = 1'b0;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			complete_run;
		end
	end
	initial begin
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		chk(emcy_en, 1'b1);
		chk(newest, 8'h00);
		log(16'h4413, 32'hc0de0001);
		idle;
		chk(emcy_entry, entry(16'h4413, 32'hc0de0001));
		chk(newest, 8'h06);
		mst.read(8'h02, got);
		chk(got[7:0], 8'h06);
		mst.read(8'h04, got);
		chk(got[0], 1'b1);
		mst.read(8'h06, got);
		chk(got, entry(16'h4413, 32'hc0de0001));
		chk(unread, 1'b0);
		mst.read(8'h03, got);
		chk(got, 160'h0);
		mst.confirm;
		mst.read(8'h06, got);
		chk(got[36], 1'b1);
		mst.set_enable(1'b0);
		mst.read(8'h05, got);
		chk(got[0], 1'b0);
		log(16'h8113, 32'h00000001);
		idle;
		chk(emcy, 1'b0);
		chk(unread, 1'b1);
		mst.set_enable(1'b1);
		for (int i = 0; i < 5; i++) begin
			log({cls[i], 4'(i + 3), 8'h21}, 32'h00000100 + 32'(i));
			idle;
			chk(emcy, 1'b1);
			chk(emcy_entry, entry(text, code));
			chk(bad, 1'b0);
		end
		log(16'h4913, 32'h00000200);
		idle;
		chk(bad, 1'b1);
		repeat (250) log(16'h1100, 32'hf0000000 | n);
		idle;
		chk(newest, 8'(6 + (n - 1) % 250));
		mst.read(8'h01, got);
		chk(got[7:0], 8'hfa);
		mst.read(newest, got);
		chk(got, entry(16'h1100, 32'hf0000000 | (n - 1)));
		complete_run;
	end
endmodule
`default_nettype wire
